//--- core/stcr_top.sv
// Serial tap control register: three-wire loader and control decode
`timescale 1ns/1ps
module stcr_top (
  input  wire logic        ref_clk,                   // System clock, 100 MHz
  input  wire logic        rst,                       // Synchronous reset, active high
  input  wire logic        serial_ctrl_data_in,       // Serial data pin
  input  wire logic        serial_ctrl_clock_in,      // Serial clock pin
  input  wire logic        serial_ctrl_write_enable,  // Load enable pin
  output logic      [3:0]  half_cur_en,               // Extra half current, index 0 = tap 1
  output logic      [3:0]  analog_en,                 // Analog section on, index 0 = tap 1
  output logic      [6:0]  buf_en,                    // Buffer on, index 0 = buffer 1
  output logic      [6:0]  buf_to_tap2,               // Buffer steered to tap 2
  output logic      [11:0] tap_units,                 // Eighths per tap, 3 bits, tap 1 low
  output logic             clk_out_sel,               // 1 = additional clock to output
  output logic             short_dly_parallel,        // Short delay parallel mode
  output logic             long_dly_parallel,         // Long delay parallel mode
  output logic      [3:0]  tap_inv,                   // Data inversion, index 0 = tap 1
  output logic             load_busy,                 // Load phase in progress
  output logic             load_count_err             // Last load was not 32 bits
);

  localparam int ASRT_SETTLE = 4;

  // Reverse a four-bit field so index 0 lands on tap 1
  function automatic logic [3:0] rev4(input logic [3:0] v);
    rev4 = {v[0], v[1], v[2], v[3]};
  endfunction

  // Reverse a seven-bit field so index 0 lands on buffer 1
  function automatic logic [6:0] rev7(input logic [6:0] v);
    rev7 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6]};
  endfunction

  // Count active digital buffers assigned to one tap
  function automatic logic [2:0] units(input logic [6:0] en, input logic [6:0] to2,
                                       input logic [2:0] tap);
    logic [2:0] n;
    logic [2:0] t;
    n = 3'h0;
    for (int i = 0; i < 7; i++) begin
      t = to2[i] ? stcr_pkg::ALT_TAP : stcr_pkg::BUF_HOME_TAP[3*i +: 3];
      if (en[i] && (t == tap)) begin
        n = n + 3'h1;
      end
    end
    units = n;
  endfunction

  logic                  clk_lvl;
  logic                  clk_fell;
  logic                  dat_lvl;
  logic                  en_lvl;
  logic                  en_fell;
  logic                  en_rose;
  stcr_pkg::stcr_state_e state_ff;
  stcr_pkg::stcr_state_e nxt_state;
  logic [31:0]           shift_ff;
  logic [31:0]           nxt_shift;
  logic [31:0]           word_ff;
  logic [31:0]           nxt_word;
  logic [5:0]            cnt_ff;
  logic [5:0]            nxt_cnt;
  logic                  err_ff;
  logic                  nxt_err;
  logic                  busy_ff;
  logic [3:0]            half_ff;
  logic [3:0]            ana_ff;
  logic [6:0]            bufen_ff;
  logic [6:0]            bufasg_ff;
  logic [11:0]           units_ff;
  logic                  clksel_ff;
  logic                  short_ff;
  logic                  long_ff;
  logic [3:0]            inv_ff;

  // Pin synchronisers; clock, data and enable share the same latency
  stcr_sync u_clk (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (serial_ctrl_clock_in),
    .level   (clk_lvl),
    .fell    (clk_fell),
    .rose    ()
  );

  stcr_sync u_dat (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (serial_ctrl_data_in),
    .level   (dat_lvl),
    .fell    (),
    .rose    ()
  );

  stcr_sync u_en (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (serial_ctrl_write_enable),
    .level   (en_lvl),
    .fell    (en_fell),
    .rose    (en_rose)
  );

  // Shifting is legal only inside the load phase
  wire shifting  = (state_ff == stcr_pkg::ST_SHIFT) && en_lvl;
  wire take_bit  = shifting && clk_fell;
  wire committed = (state_ff == stcr_pkg::ST_COMMIT);
  wire cnt_sat   = (cnt_ff == stcr_pkg::CNT_MAX);

  // Sequencer: enable rise opens a load, enable fall closes it
  // A fall seen while idle is dropped, so no stray commit can happen
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      stcr_pkg::ST_IDLE: begin
        if (en_rose) begin
          nxt_state = stcr_pkg::ST_SHIFT;
        end
      end
      stcr_pkg::ST_SHIFT: begin
        if (en_fell) begin
          nxt_state = stcr_pkg::ST_COMMIT;
        end
      end
      stcr_pkg::ST_COMMIT: begin
        nxt_state = stcr_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = stcr_pkg::ST_IDLE;
      end
    endcase
  end

  // Bits enter at the top and walk down, so the first ends in bit 0
  assign nxt_shift = take_bit ? {dat_lvl, shift_ff[31:1]} : shift_ff;

  // Bit counter restarts with each load and saturates on overrun
  assign nxt_cnt = en_rose ? stcr_pkg::CNT_RST :
                   (take_bit && !cnt_sat) ? cnt_ff + 6'h01 : cnt_ff;

  // Word is copied once per load; otherwise the last load is held
  assign nxt_word = committed ? shift_ff : word_ff;
  assign nxt_err  = committed ? (cnt_ff != stcr_pkg::CNT_FULL) : err_ff;

  // Sequencer and shift path registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= stcr_pkg::ST_IDLE;
      shift_ff <= stcr_pkg::WORD_RST;
      cnt_ff   <= stcr_pkg::CNT_RST;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Committed word and load status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_ff <= stcr_pkg::WORD_RST;
      err_ff  <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      word_ff <= nxt_word;
      err_ff  <= nxt_err;
      busy_ff <= (nxt_state != stcr_pkg::ST_IDLE);
    end
  end

  // Field decode; bits 15, 23 and 31 are deliberately left unread
  wire [3:0] dec_half  = rev4(word_ff[stcr_pkg::HALF_LSB +: 4]);
  wire [3:0] dec_ana   = rev4(word_ff[stcr_pkg::ANA_LSB +: 4]);
  wire [6:0] dec_bufen = rev7(word_ff[stcr_pkg::BUFEN_LSB +: 7]);
  wire [6:0] dec_asg   = rev7(word_ff[stcr_pkg::BUFASG_LSB +: 7]);
  wire [3:0] dec_inv   = rev4(word_ff[stcr_pkg::INV_LSB +: 4]);
  wire [11:0] dec_units = {units(dec_bufen, dec_asg, 3'h4),
                           units(dec_bufen, dec_asg, 3'h3),
                           units(dec_bufen, dec_asg, 3'h2),
                           units(dec_bufen, dec_asg, 3'h1)};

  // Registered control outputs; one stage keeps them glitch free
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_ff   <= 4'h0;
      ana_ff    <= 4'h0;
      bufen_ff  <= 7'h00;
      bufasg_ff <= 7'h00;
      units_ff  <= 12'h000;
      clksel_ff <= 1'b0;
      short_ff  <= 1'b0;
      long_ff   <= 1'b0;
      inv_ff    <= 4'h0;
    end else begin
      half_ff   <= dec_half;
      ana_ff    <= dec_ana;
      bufen_ff  <= dec_bufen;
      bufasg_ff <= dec_asg;
      units_ff  <= dec_units;
      clksel_ff <= word_ff[stcr_pkg::CLKSEL_BIT];
      short_ff  <= word_ff[stcr_pkg::SHORT_BIT];
      long_ff   <= word_ff[stcr_pkg::LONG_BIT];
      inv_ff    <= dec_inv;
    end
  end

  // Output wiring, all from flip-flops
  assign half_cur_en        = half_ff;
  assign analog_en          = ana_ff;
  assign buf_en             = bufen_ff;
  assign buf_to_tap2        = bufasg_ff;
  assign tap_units          = units_ff;
  assign clk_out_sel        = clksel_ff;
  assign short_dly_parallel = short_ff;
  assign long_dly_parallel  = long_ff;
  assign tap_inv            = inv_ff;
  assign load_busy          = busy_ff;
  assign load_count_err     = err_ff;

  // Commit step: enable fall, commit state, copy, decode
  sequence s_close;
    en_fell ##1 committed;
  endsequence

  sequence s_settled;
    (word_ff == $past(shift_ff)) ##1 (tap_inv == rev4(word_ff[stcr_pkg::INV_LSB +: 4]));
  endsequence

  a_shift_on_fall: assert property (@(posedge ref_clk) disable iff (rst)
    take_bit |=> shift_ff == {$past(dat_lvl), $past(shift_ff[31:1])})
    else $error("shift did not take the bit on a clock fall");

  a_no_shift_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !shifting |=> shift_ff == $past(shift_ff))
    else $error("shift register moved outside the load phase");

  a_word_held: assert property (@(posedge ref_clk) disable iff (rst)
    !committed |=> $stable(word_ff))
    else $error("control word changed without a commit");

  a_commit_path: assert property (@(posedge ref_clk) disable iff (rst)
    s_close |=> s_settled)
    else $error("commit did not copy and decode the shifted word");

  a_half_map: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 half_cur_en == {$past(word_ff[0]), $past(word_ff[1]),
                        $past(word_ff[2]), $past(word_ff[3])})
    else $error("half current bits misrouted");

  a_analog_map: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 analog_en[0] == $past(word_ff[7]) && analog_en[3] == $past(word_ff[4]))
    else $error("analog enable bits misrouted");

  a_buf_map: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 buf_en[0] == $past(word_ff[14]) && buf_en[6] == $past(word_ff[8])
        && buf_to_tap2[0] == $past(word_ff[22]) && buf_to_tap2[6] == $past(word_ff[16]))
    else $error("buffer enable or assignment misrouted");

  a_units_all_tap2: assert property (@(posedge ref_clk) disable iff (rst)
    (word_ff[22:16] == 7'h7F && word_ff[14:8] == 7'h7F) |=> tap_units[5:3] == 3'h7)
    else $error("tap 2 unit count wrong with all buffers steered");

  a_mode_bits: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 clk_out_sel == $past(word_ff[24]) && short_dly_parallel == $past(word_ff[25])
        && long_dly_parallel == $past(word_ff[26]) && tap_inv[3] == $past(word_ff[27]))
    else $error("clock select, delay polarity or inversion misrouted");

  a_settle_time: assert property (@(posedge ref_clk) disable iff (rst)
    en_fell |-> ##[1:ASRT_SETTLE] (tap_inv == rev4(shift_ff[stcr_pkg::INV_LSB +: 4])))
    else $error("new controls did not settle in time");

  // Load bookkeeping; a short frame is still committed to the word and also sets the count flag
  sequence s_open;
    en_rose ##1 (state_ff == stcr_pkg::ST_SHIFT);
  endsequence

  a_load_open: assert property (@(posedge ref_clk) disable iff (rst)
    s_open |-> (cnt_ff == stcr_pkg::CNT_RST) && load_busy)
    else $error("load did not open with a cleared bit count");

  a_count_flag: assert property (@(posedge ref_clk) disable iff (rst)
    committed |=> load_count_err == ($past(cnt_ff) != stcr_pkg::CNT_FULL))
    else $error("bit count flag wrong after commit");

  a_flag_held: assert property (@(posedge ref_clk) disable iff (rst)
    !committed |=> $stable(load_count_err))
    else $error("bit count flag changed without a commit");

  a_busy_phase: assert property (@(posedge ref_clk) disable iff (rst)
    load_busy == (state_ff != stcr_pkg::ST_IDLE))
    else $error("busy flag does not follow the load phase");

  a_inv_map: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 tap_inv == {$past(word_ff[27]), $past(word_ff[28]),
                    $past(word_ff[29]), $past(word_ff[30])})
    else $error("inversion bits misrouted");

  a_units_home: assert property (@(posedge ref_clk) disable iff (rst)
    (word_ff[22:16] == 7'h00 && word_ff[14:8] == 7'h7F)
    |=> tap_units == {3'h2, 3'h3, 3'h0, 3'h2})
    else $error("home tap unit counts wrong with no buffer steered");

endmodule

//--- core/stcr_pkg.sv
// Constants, field layout and states of the serial tap control register
//
// Contract
// - Thirty-two bit serial register drives driver controls
// - Shift one bit per serial clock fall
// - First serial bit lands in bit zero
// - Enable low keeps loaded controls unchanged
// - Bits 0-3 enable half current, taps 4-1
// - Bits 4-7 enable analog sections, taps 4-1
// - Bits 8-14 activate digital buffers 7-1
// - Bits 16-22 steer buffers 7-1 to tap 2
// - Bit 24 picks additional or main clock
// - Bit 25 one means parallel short delay
// - Bit 26 one means parallel long delay
// - Bits 27-30 invert data, taps 4-1
// - New controls settle within 100 ns
package stcr_pkg;

  // Word geometry
  localparam int unsigned WORD_W  = 32;
  localparam int unsigned CNT_W   = 6;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [5:0]  CNT_RST  = 6'h00;
  localparam logic [5:0]  CNT_FULL = 6'h20;
  localparam logic [5:0]  CNT_MAX  = 6'h3F;

  // Field positions inside the control word
  localparam int unsigned HALF_LSB   = 0;
  localparam int unsigned ANA_LSB    = 4;
  localparam int unsigned BUFEN_LSB  = 8;
  localparam int unsigned BUFASG_LSB = 16;
  localparam int unsigned CLKSEL_BIT = 24;
  localparam int unsigned SHORT_BIT  = 25;
  localparam int unsigned LONG_BIT   = 26;
  localparam int unsigned INV_LSB    = 27;

  // Home tap of buffers 7 down to 1 when not steered to tap 2
  localparam logic [20:0] BUF_HOME_TAP = {3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h1, 3'h1};
  localparam logic [2:0]  ALT_TAP      = 3'h2;

  // Settling budget for a new control word
  localparam int unsigned RECONF_NS  = 100;
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned RECONF_CYC = (RECONF_NS * CLK_MHZ) / 1000;

  // Load sequencer, Gray coded along idle, shift, commit
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SHIFT  = 2'h1,
    ST_COMMIT = 2'h3
  } stcr_state_e;

endpackage

//--- core/stcr_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module stcr_sync (
  input  wire logic ref_clk,  // System clock
  input  wire logic rst,      // Synchronous reset, active high
  input  wire logic pin,      // Asynchronous pin level
  output logic      level,    // Filtered level
  output logic      fell,     // One-cycle pulse on accepted fall
  output logic      rose      // One-cycle pulse on accepted rise
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic fell_ff;
  logic rose_ff;
  wire  agree = (s2_ff == s3_ff);

  // Chain; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    s1_ff <= pin;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  // Level moves only once the later stages agree, hiding metastable glitches
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_ff <= 1'b0;
      fell_ff  <= 1'b0;
      rose_ff  <= 1'b0;
    end else begin
      level_ff <= agree ? s3_ff : level_ff;
      fell_ff  <= agree & level_ff & ~s3_ff;
      rose_ff  <= agree & ~level_ff & s3_ff;
    end
  end

  assign level = level_ff;
  assign fell  = fell_ff;
  assign rose  = rose_ff;

endmodule

//--- verif/stcr_ctrl_model.sv
// Behavioural three-wire controller that loads control words
`timescale 1ns/1ps
module stcr_ctrl_model (
  output logic serial_ctrl_data_in,      // Serial data pin
  output logic serial_ctrl_clock_in,     // Serial clock pin, low through reset, idles high between frames
  output logic serial_ctrl_write_enable  // Load enable pin
);
  // Half of the 125 ns link clock, unrelated to the system clock
  localparam realtime HALF = 62.5;

  // Pins idle low through reset
  initial begin
    serial_ctrl_data_in = 1'b0;
    serial_ctrl_clock_in = 1'b0;
    serial_ctrl_write_enable = 1'b0;
  end

  // One frame; data moves on clock rise so it is steady around each fall
  task automatic send(input logic [63:0] bits, input int n);
    serial_ctrl_clock_in = 1'b1;
    #(HALF);
    serial_ctrl_write_enable = 1'b1;
    #100;
    for (int i = 0; i < n; i++) begin
      serial_ctrl_data_in = bits[i];
      #(HALF);
      serial_ctrl_clock_in = 1'b0;
      #(HALF);
      serial_ctrl_clock_in = 1'b1;
    end
    // Last fall must be seen before enable drops
    #100;
    serial_ctrl_write_enable = 1'b0;
    serial_ctrl_data_in = ~serial_ctrl_data_in;
  endtask

  // Clock falls with enable low, data changing each time
  task automatic idle_toggle(input int n);
    for (int i = 0; i < n; i++) begin
      serial_ctrl_data_in = ~serial_ctrl_data_in;
      #(HALF);
      serial_ctrl_clock_in = 1'b0;
      #(HALF);
      serial_ctrl_clock_in = 1'b1;
    end
  endtask
endmodule

//--- verif/test_serial_tap_control_register.sv
// Self-checking bench for the serial tap control register
`timescale 1ns/1ps
module test_serial_tap_control_register;
  logic        ref_clk;
  logic        rst;
  logic        serial_ctrl_data_in;
  logic        serial_ctrl_clock_in;
  logic        serial_ctrl_write_enable;
  logic [3:0]  half_cur_en;
  logic [3:0]  analog_en;
  logic [6:0]  buf_en;
  logic [6:0]  buf_to_tap2;
  logic [11:0] tap_units;
  logic        clk_out_sel;
  logic        short_dly_parallel;
  logic        long_dly_parallel;
  logic [3:0]  tap_inv;
  logic        load_busy;
  logic        load_count_err;
  int          bad_count = 0;
  int          check_count = 0;
  wire  [42:0] obs = {half_cur_en, analog_en, buf_en, buf_to_tap2, tap_units, clk_out_sel,
                      short_dly_parallel, long_dly_parallel, tap_inv, load_busy,
                      load_count_err};

  stcr_ctrl_model model_i (
    .serial_ctrl_data_in      (serial_ctrl_data_in),
    .serial_ctrl_clock_in     (serial_ctrl_clock_in),
    .serial_ctrl_write_enable (serial_ctrl_write_enable)
  );

  stcr_top stcr_top_i (
    .ref_clk                  (ref_clk),
    .rst                      (rst),
    .serial_ctrl_data_in      (serial_ctrl_data_in),
    .serial_ctrl_clock_in     (serial_ctrl_clock_in),
    .serial_ctrl_write_enable (serial_ctrl_write_enable),
    .half_cur_en              (half_cur_en),
    .analog_en                (analog_en),
    .buf_en                   (buf_en),
    .buf_to_tap2              (buf_to_tap2),
    .tap_units                (tap_units),
    .clk_out_sel              (clk_out_sel),
    .short_dly_parallel       (short_dly_parallel),
    .long_dly_parallel        (long_dly_parallel),
    .tap_inv                  (tap_inv),
    .load_busy                (load_busy),
    .load_count_err           (load_count_err)
  );

  // 100 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Expected ports for a committed word; home taps 1,1,3,3,3,4,4
  function automatic logic [42:0] exp_of(input logic [31:0] w, input logic err);
    logic [3:0] h, a, v;
    logic [6:0] b, s;
    logic [2:0] t1, t2, t3, t4;
    t1 = 3'h0;
    t2 = 3'h0;
    t3 = 3'h0;
    t4 = 3'h0;
    for (int k = 0; k < 4; k++) begin
      h[k] = w[3-k];
      a[k] = w[7-k];
      v[k] = w[30-k];
    end
    for (int j = 0; j < 7; j++) begin
      b[j] = w[14-j];
      s[j] = w[22-j];
      if (b[j] && s[j]) t2 = t2 + 3'h1;
      else if (b[j] && j < 2) t1 = t1 + 3'h1;
      else if (b[j] && j < 5) t3 = t3 + 3'h1;
      else if (b[j]) t4 = t4 + 3'h1;
    end
    return {h, a, b, s, t4, t3, t2, t1, w[24], w[25], w[26], v, 1'b0, err};
  endfunction

  task automatic check(input logic [42:0] got, input logic [42:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Load a frame, then allow ten cycles for the new controls to settle
  task automatic load_check(input logic [63:0] bits, input int n, input logic [31:0] w,
                            input logic err);
    logic [42:0] e;
    e = exp_of(w, err);
    fork
      model_i.send(bits, n);
      begin
        repeat (20) @(posedge ref_clk);
        #1;
        check({42'h0, load_busy}, 43'h1, "busy during load");
      end
    join
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      #1;
      if (obs === e) break;
    end
    check(obs, e, "controls after load");
  endtask

  // Mixed words; every mode bit seen at both values
  task automatic t_words();
    logic [31:0] tbl [6];
    tbl = '{32'hA5C3_5A3E, 32'h5A3C_A5C7, 32'h0055_7F0F, 32'h007F_7F02,
            32'h0000_7F0F, 32'h0000_4008};
    foreach (tbl[i]) load_check({32'h0, tbl[i]}, 32, tbl[i], 1'b0);
  endtask

  // Spare bits alone move nothing
  task automatic t_unused();
    load_check({32'h0, 32'h8080_8000}, 32, 32'h8080_8000, 1'b0);
  endtask

  // Falls with enable low leave the word and the shift path alone
  task automatic t_hold();
    load_check({32'h0, 32'h0055_7F0F}, 32, 32'h0055_7F0F, 1'b0);
    model_i.idle_toggle(8);
    repeat (12) @(posedge ref_clk);
    #1;
    check(obs, exp_of(32'h0055_7F0F, 1'b0), "hold with enable low");
    // Short frame keeps the old upper half low, so any stray shift shows
    load_check({48'h0, 16'h3C00}, 16, 32'h3C00_0055, 1'b1);
  endtask

  // Thirty-three bits keep the last 32 and flag the count
  task automatic t_overlong();
    load_check({31'h0, 32'h5A3C_A5C7, 1'b1}, 33, 32'h5A3C_A5C7, 1'b1);
    load_check({32'h0, 32'h0000_4008}, 32, 32'h0000_4008, 1'b0);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    check(obs, 43'h0, "reset state");
    t_words();
    t_unused();
    t_hold();
    t_overlong();
    tally_and_finish();
  end

  // Hang guard, well beyond eleven frames of about 4.3 us
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
